//--- verilog/ata_host_port.sv
`timescale 1ns/10ps
module ata_host_port (
  // Clock, reset, enable
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_ce,
  // Host register access
  input wire logic [2:0] i_addr,
  input wire logic i_cmd_block_select_n,
  input wire logic i_ctrl_block_select_n,
  input wire logic i_host_read_strobe_n,
  input wire logic i_host_write_strobe_n,
  input wire logic [15:0] i_data,
  output logic [15:0] o_data,
  output logic o_data_oe,
  // DMA handshake
  input wire logic i_dma_ack_n,
  output logic o_dma_req,
  // Mode and configuration
  input wire logic i_udma_mode,
  input wire logic i_cable_select,
  output logic o_is_slave,
  // Drive-side data source
  input wire logic i_src_valid,
  input wire logic [15:0] i_src_data,
  output logic o_src_ready,
  // Drive-side view of host device-control writes, and the alternate status it supplies
  output logic [7:0] o_dev_ctrl,
  input wire logic [7:0] i_alt_status
);
  logic [15:0] regs_q [0:7];
  logic [15:0] regs_d [0:7];
  logic [7:0] dev_ctrl_q, dev_ctrl_d;
  logic [15:0] data_q, data_d;
  logic data_oe_q, data_oe_d;
  logic dma_req_q, dma_req_d;
  logic is_slave_q, is_slave_d;
  logic strap_done_q, strap_done_d;
  logic src_ready_q, src_ready_d;
  logic wr_prev_q;
  logic [7:0] wr_hit;
  host_port_pkg::xfer_state_t st_q, st_d;
  logic buf_valid, buf_ready, buf_pop, buf_push, host_ready, cmd_sel, ctrl_sel;
  logic [15:0] buf_data;

  function automatic logic [7:0] one_hot(input logic [2:0] a);
    one_hot = 8'h01 << a;
  endfunction : one_hot

  word_buf u_buf (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .i_ce(i_ce),
    .i_in_valid(buf_push),
    .i_in_data(i_src_data),
    .o_in_ready(buf_ready),
    .o_out_valid(buf_valid),
    .o_out_data(buf_data),
    .i_out_ready(buf_pop)
  );

  always_comb begin
    cmd_sel = !i_cmd_block_select_n && i_ctrl_block_select_n;
    ctrl_sel = !i_ctrl_block_select_n && i_cmd_block_select_n;
    host_ready = !i_host_read_strobe_n;
    wr_hit = one_hot(i_addr);
    buf_push = i_src_valid && src_ready_q;
    buf_pop = 1'b0;
    st_d = st_q;
    dma_req_d = dma_req_q;
    data_d = data_q;
    data_oe_d = 1'b0;
    for (int i = 0; i < 8; i++) begin
      regs_d[i] = regs_q[i];
    end
    dev_ctrl_d = dev_ctrl_q;
    // Writes land on the rising edge of the write strobe
    if (!wr_prev_q && i_host_write_strobe_n && !i_udma_mode) begin
      if (cmd_sel) begin
        for (int i = 0; i < 8; i++) begin
          if (wr_hit[i]) begin
            regs_d[i] = i_data;
          end
        end
      end else if (ctrl_sel && i_addr == host_port_pkg::CTRL_ALT_STATUS_IDX) begin
        dev_ctrl_d = i_data[7:0];
      end
    end
    case (st_q)
      host_port_pkg::XFER_IDLE: begin
        if (buf_valid && i_udma_mode) begin
          dma_req_d = 1'b1;
          st_d = host_port_pkg::XFER_REQ;
        end
      end
      host_port_pkg::XFER_REQ: begin
        if (!i_dma_ack_n) begin
          st_d = host_port_pkg::XFER_SEND;
        end
      end
      host_port_pkg::XFER_SEND: begin
        if (i_dma_ack_n || !i_udma_mode) begin
          dma_req_d = 1'b0;
          st_d = host_port_pkg::XFER_IDLE;
        end else if (!host_ready) begin
          st_d = host_port_pkg::XFER_PAUSE;
          // Keep showing a word already sent, never stale register data
          data_oe_d = data_oe_q;
        end else if (buf_valid) begin
          buf_pop = 1'b1;
          data_d = buf_data;
          data_oe_d = 1'b1;
        end else begin
          dma_req_d = 1'b0;
          st_d = host_port_pkg::XFER_IDLE;
        end
      end
      host_port_pkg::XFER_PAUSE: begin
        if (i_dma_ack_n || !i_udma_mode) begin
          dma_req_d = 1'b0;
          st_d = host_port_pkg::XFER_IDLE;
        end else begin
          data_oe_d = data_oe_q;
          if (host_ready) begin
            st_d = host_port_pkg::XFER_SEND;
          end
        end
      end
      default: st_d = host_port_pkg::XFER_IDLE;
    endcase
    // Ready is registered, so it must already allow for this cycle's push and pop
    src_ready_d = buf_ready && !(buf_valid && buf_push && !buf_pop);
    // PIO and register reads
    if (!i_udma_mode && !i_host_read_strobe_n) begin
      if (cmd_sel) begin
        data_d = regs_q[i_addr];
        data_oe_d = 1'b1;
      end else if (ctrl_sel && i_addr == host_port_pkg::CTRL_ALT_STATUS_IDX) begin
        data_d = {8'h00, i_alt_status};
        data_oe_d = 1'b1;
      end
    end
  end

  // Strap is caught once after reset since it never changes while powered
  always_comb begin
    strap_done_d = 1'b1;
    is_slave_d = strap_done_q ? is_slave_q : i_cable_select;
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      for (int i = 0; i < 8; i++) begin
        regs_q[i] <= host_port_pkg::REG_RESET_VAL;
      end
      dev_ctrl_q <= host_port_pkg::DEV_CTRL_RESET_VAL;
      data_q <= host_port_pkg::REG_RESET_VAL;
      data_oe_q <= 1'b0;
      dma_req_q <= 1'b0;
      st_q <= host_port_pkg::XFER_IDLE;
      is_slave_q <= 1'b1;
      strap_done_q <= 1'b0;
      src_ready_q <= 1'b0;
      wr_prev_q <= 1'b1;
    end else if (i_ce) begin
      for (int i = 0; i < 8; i++) begin
        regs_q[i] <= regs_d[i];
      end
      dev_ctrl_q <= dev_ctrl_d;
      data_q <= data_d;
      data_oe_q <= data_oe_d;
      dma_req_q <= dma_req_d;
      st_q <= st_d;
      is_slave_q <= is_slave_d;
      strap_done_q <= strap_done_d;
      src_ready_q <= src_ready_d;
      wr_prev_q <= i_host_write_strobe_n;
    end
  end

  assign o_data = data_q;
  assign o_data_oe = data_oe_q;
  assign o_dma_req = dma_req_q;
  assign o_is_slave = is_slave_q;
  assign o_dev_ctrl = dev_ctrl_q;
  // Ready looks one word ahead, so a stalled drain never loses a word
  assign o_src_ready = src_ready_q;

  a_pause_holds: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (i_ce && st_q == host_port_pkg::XFER_SEND && !host_ready && !i_dma_ack_n && i_udma_mode)
    |=> st_q == host_port_pkg::XFER_PAUSE)
    else $error("data continued while host not ready");
  a_req_on_data: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (i_ce && st_q == host_port_pkg::XFER_IDLE && buf_valid && i_udma_mode) |=> o_dma_req)
    else $error("dma request not raised");
  a_strap_fixed: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    strap_done_q |=> $stable(o_is_slave))
    else $error("role changed while powered");
  a_no_sel_read: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (i_ce && i_cmd_block_select_n && i_ctrl_block_select_n && st_q == host_port_pkg::XFER_IDLE)
    |=> !o_data_oe)
    else $error("data driven without a select");

  sequence s_word_taken;
    i_ce && st_q == host_port_pkg::XFER_SEND && !i_dma_ack_n && i_udma_mode && host_ready &&
      buf_valid;
  endsequence

  a_word_out: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    s_word_taken |=> (o_data_oe && o_data == $past(buf_data)))
    else $error("dma word not shown");
  a_pause_steady: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (i_ce && i_udma_mode && st_q == host_port_pkg::XFER_PAUSE) |=> $stable(o_data))
    else $error("data changed during pause");
  a_cmd_read_oe: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (i_ce && !i_udma_mode && !i_host_read_strobe_n && cmd_sel) |=> o_data_oe)
    else $error("register read not driven");
  a_ctrl_read_alt: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (i_ce && !i_udma_mode && !i_host_read_strobe_n && ctrl_sel &&
      i_addr == host_port_pkg::CTRL_ALT_STATUS_IDX)
    |=> (o_data_oe && o_data[7:0] == $past(i_alt_status)))
    else $error("alternate status not shown");
endmodule : ata_host_port

//--- pkg/host_port_pkg.sv
package host_port_pkg;
  localparam int unsigned ADDR_W = 3;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned NUM_CMD_REGS = 8;
  localparam logic [2:0] CMD_DATA_IDX = 3'h0;
  localparam logic [2:0] CTRL_ALT_STATUS_IDX = 3'h6;
  localparam logic [15:0] REG_RESET_VAL = 16'h0000;
  localparam logic [7:0] DEV_CTRL_RESET_VAL = 8'h00;
  localparam logic [7:0] ALT_STATUS_RESET_VAL = 8'h50;
  localparam int unsigned BUF_DEPTH = 2;
  typedef enum logic [1:0] {
    XFER_IDLE,
    XFER_REQ,
    XFER_SEND,
    XFER_PAUSE
  } xfer_state_t;
endpackage : host_port_pkg

//--- verilog/word_buf.sv
`timescale 1ns/10ps
module word_buf (
  // Clock, reset, enable
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_ce,
  // Fill side
  input wire logic i_in_valid,
  input wire logic [15:0] i_in_data,
  output logic o_in_ready,
  // Drain side
  output logic o_out_valid,
  output logic [15:0] o_out_data,
  input wire logic i_out_ready
);
  logic [15:0] mem_q [0:1];
  logic [15:0] mem_d [0:1];
  logic wr_ptr_q, wr_ptr_d, rd_ptr_q, rd_ptr_d;
  logic [1:0] cnt_q, cnt_d;
  logic push, pop;

  always_comb begin
    push = i_in_valid && (cnt_q != 2'(host_port_pkg::BUF_DEPTH));
    pop = i_out_ready && (cnt_q != 2'h0);
    mem_d[0] = mem_q[0];
    mem_d[1] = mem_q[1];
    if (push) begin
      mem_d[wr_ptr_q] = i_in_data;
    end
    wr_ptr_d = push ? ~wr_ptr_q : wr_ptr_q;
    rd_ptr_d = pop ? ~rd_ptr_q : rd_ptr_q;
    cnt_d = cnt_q + {1'b0, push} - {1'b0, pop};
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      mem_q[0] <= host_port_pkg::REG_RESET_VAL;
      mem_q[1] <= host_port_pkg::REG_RESET_VAL;
      wr_ptr_q <= 1'b0;
      rd_ptr_q <= 1'b0;
      cnt_q <= 2'h0;
    end else if (i_ce) begin
      mem_q[0] <= mem_d[0];
      mem_q[1] <= mem_d[1];
      wr_ptr_q <= wr_ptr_d;
      rd_ptr_q <= rd_ptr_d;
      cnt_q <= cnt_d;
    end
  end

  assign o_in_ready = (cnt_q != 2'(host_port_pkg::BUF_DEPTH));
  assign o_out_valid = (cnt_q != 2'h0);
  assign o_out_data = mem_q[rd_ptr_q];
endmodule : word_buf

//--- verification/host_dma_model.sv
`timescale 1ns/10ps
module host_dma_model (
  // Clock and control
  input wire logic i_clk_sys,
  input wire logic i_go,
  // Device side
  input wire logic i_dma_req,
  input wire logic i_data_oe,
  input wire logic [15:0] i_data,
  output logic o_dma_ack_n = 1'b1,
  output logic o_host_ready_n = 1'b1
);
  logic [1:0] phase_q = 2'h0;
  logic [15:0] last_q = 16'h0000;
  logic [15:0] got_q[$];
  always @(posedge i_clk_sys) begin
    phase_q <= phase_q + 2'h1;
    // Words are distinct, so a new value on the bus marks a new word
    if (i_data_oe && !o_dma_ack_n && i_data !== last_q) begin
      got_q.push_back(i_data);
      last_q <= i_data;
    end
    o_dma_ack_n <= #10 !(i_go && i_dma_req);
    o_host_ready_n <= #10 !i_go || (phase_q == 2'h3);
  end
endmodule : host_dma_model

//--- verification/ata_host_port_signals_test.sv
`timescale 1ns/10ps
module ata_host_port_signals_test;
  logic clk = 1'b0, rst_n = 1'b0, wr_n = 1'b1, rd_n = 1'b1, udma = 1'b0, go = 1'b0;
  logic ce = 1'b1;
  logic csel = 1'b0; // Moves only while reset is held
  logic cmd_n = 1'b1, ctrl_n = 1'b1, src_valid = 1'b0, src_ready, dma_req, oe, is_slave;
  logic [2:0] addr = 3'h0;
  logic [15:0] wdata = 16'h0000, src_data = 16'h0000, rdata, wv[8], exp_q[$];
  logic [7:0] alt = 8'h00, dev_ctrl;
  logic ack_n, hrdy_n;
  int fails = 0, num_checks = 0;
  logic [31:0] seed = 32'h00010f34;
  always #50 clk = ~clk;
  ata_host_port dut_u (.i_clk_sys(clk), .i_rst_n(rst_n), .i_ce(ce), .i_addr(addr),
    .i_cmd_block_select_n(cmd_n), .i_ctrl_block_select_n(ctrl_n),
    .i_host_read_strobe_n(udma ? hrdy_n : rd_n), .i_host_write_strobe_n(wr_n),
    .i_data(wdata), .o_data(rdata), .o_data_oe(oe), .i_dma_ack_n(ack_n), .o_dma_req(dma_req),
    .i_udma_mode(udma), .i_cable_select(csel), .o_is_slave(is_slave), .i_src_valid(src_valid),
    .i_src_data(src_data), .o_src_ready(src_ready), .o_dev_ctrl(dev_ctrl), .i_alt_status(alt));
  host_dma_model host_u (.i_clk_sys(clk), .i_go(go), .i_dma_req(dma_req), .i_data_oe(oe),
    .i_data(rdata), .o_dma_ack_n(ack_n), .o_host_ready_n(hrdy_n));
  function automatic logic [15:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed[15:0] | 16'h0001;
  endfunction : rnd
  task automatic tick(int n = 1);
    repeat (n) @(posedge clk);
    #10;
  endtask : tick
  task automatic chk_word(string what, logic [15:0] exp, logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_word
  task automatic chk_bit(string what, logic exp, logic got);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value %s expected %b seen %b", what, exp, got);
    end
  endtask : chk_bit
  task automatic chk_count(string what, int exp, int got);
    num_checks++;
    if (got != exp) begin
      fails++;
      $display("wrong value %s expected %0d seen %0d", what, exp, got);
    end
  endtask : chk_count
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : wrap_up
  task automatic wr(logic [1:0] sel, logic [2:0] a, logic [15:0] d);
    {ctrl_n, cmd_n} = sel;
    addr = a;
    wdata = d;
    wr_n = 1'b0;
    tick();
    wr_n = 1'b1;
    tick();
    {ctrl_n, cmd_n} = 2'h3;
    tick();
  endtask : wr
  task automatic rd(logic [1:0] sel, logic [2:0] a);
    {ctrl_n, cmd_n} = sel;
    addr = a;
    rd_n = 1'b0;
    tick(2);
  endtask : rd
  task automatic rd_end();
    rd_n = 1'b1;
    {ctrl_n, cmd_n} = 2'h3;
    tick();
  endtask : rd_end
  task automatic push();
    bit ok = 0;
    src_data = rnd();
    src_valid = 1'b1;
    for (int n = 0; n < 60 && !ok; n++) begin
      @(posedge clk);
      ok = (src_ready === 1'b1);
    end
    #10;
    if (!ok) begin
      fails++;
      wrap_up();
    end
    exp_q.push_back(src_data);
  endtask : push
  initial begin
    tick(4);
    chk_bit("reset req", 1'b0, dma_req);
    chk_bit("reset oe", 1'b0, oe);
    rst_n = 1'b1;
    tick(2);
    chk_bit("is_slave", 1'b0, is_slave);
    for (int a = 0; a < 8; a++) begin
      wv[a] = rnd();
      wr(2'h2, a[2:0], wv[a]);
    end
    // Clock enable low: this write must leave no trace
    ce = 1'b0;
    wr(2'h2, 3'h2, ~wv[2]);
    ce = 1'b1;
    for (int a = 0; a < 8; a++) begin
      rd(2'h2, a[2:0]);
      chk_word("cmd reg", wv[a], rdata);
      chk_bit("cmd oe", 1'b1, oe);
      rd_end();
    end
    rd(2'h0, 3'h1);
    chk_bit("both selects oe", 1'b0, oe);
    rd_end();
    rd(2'h3, 3'h1);
    chk_bit("no select oe", 1'b0, oe);
    rd_end();
    alt = 8'(rnd());
    rd(2'h1, 3'h6);
    chk_word("alt status", {8'h00, alt}, rdata);
    rd_end();
    wdata = rnd();
    wr(2'h1, 3'h6, wdata);
    chk_word("dev ctrl", {8'h00, wdata[7:0]}, {8'h00, dev_ctrl});
    $display("register test done");
    udma = 1'b1;
    wr(2'h2, 3'h1, ~wv[1]);
    push();
    push();
    src_valid = 1'b0;
    tick(3);
    chk_bit("dma req", 1'b1, dma_req);
    chk_bit("buffer full", 1'b0, src_ready);
    chk_bit("oe before ack", 1'b0, oe);
    go = 1'b1;
    repeat (6) push();
    src_valid = 1'b0;
    for (int n = 0; n < 200 && host_u.got_q.size() < 8; n++) tick();
    chk_count("word count", 8, host_u.got_q.size());
    for (int i = 0; i < 8 && i < host_u.got_q.size(); i++)
      chk_word("dma word", exp_q[i], host_u.got_q[i]);
    tick(3);
    chk_bit("req idle", 1'b0, dma_req);
    $display("dma test done");
    udma = 1'b0;
    go = 1'b0;
    tick(2);
    rd(2'h2, 3'h1);
    chk_word("write in udma", wv[1], rdata);
    rd_end();
    // Cable select moves only while reset holds, as at a fresh power-on
    csel = 1'b1;
    rst_n = 1'b0;
    tick(4);
    chk_bit("reset req", 1'b0, dma_req);
    chk_bit("reset oe", 1'b0, oe);
    rst_n = 1'b1;
    tick(2);
    chk_bit("is_slave", 1'b1, is_slave);
    rd(2'h2, 3'h1);
    chk_word("reg after reset", host_port_pkg::REG_RESET_VAL, rdata);
    rd_end();
    $display("reset test done");
    wrap_up();
  end
endmodule : ata_host_port_signals_test
